// *** hdl/ith_defs.vh ***
// Constants for the three-channel interval timer host port.
`ifndef ITH_DEFS_VH
`define ITH_DEFS_VH
`define ITH_PORT_CTRL     2'h3
`define ITH_CW_SEL_HI     7
`define ITH_CW_SEL_LO     6
`define ITH_CW_RL_HI      5
`define ITH_CW_RL_LO      4
`define ITH_CW_MODE_HI    3
`define ITH_CW_MODE_LO    1
`define ITH_CW_BCD        0
`define ITH_SEL_ILLEGAL   2'h3
`define ITH_RL_LATCH      2'h0
`define ITH_RL_LSB        2'h1
`define ITH_RL_MSB        2'h2
`define ITH_RL_BOTH       2'h3
`define ITH_CW_RESET      8'h36
`define ITH_MAX_RATE_KHZ  2000
`define ITH_CLK_KHZ       100000
`define ITH_MIN_CLK_CYC   (`ITH_CLK_KHZ / `ITH_MAX_RATE_KHZ)
`endif

// *** hdl/ith_edge_sync.v ***
// Edge detector for one count clock or gate input.
`timescale 1ns/1ns
module ith_edge_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire resetn,
  // Sampled level and edges
  input  wire level_in,
  output wire rise,
  output wire fall
);
  reg prev_q;
  reg live_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
      live_q <= 1'b0;
    end else begin
      prev_q <= level_in;
      live_q <= 1'b1;
    end
  end
  // No edge is reported before one real sample exists, so a pin idling high gives no false edge after reset.
  assign rise = live_q & level_in & ~prev_q;
  assign fall = live_q & ~level_in & prev_q;
endmodule

// *** hdl/ith_counter.v ***
// One 16-bit presettable down counter with its own configuration.
`timescale 1ns/1ns
`include "ith_defs.vh"
module ith_counter (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Configuration
  input  wire        cfg_we,
  input  wire [5:0]  cfg_word,
  input  wire        latch_cmd,
  // Count byte access
  input  wire        load_we,
  input  wire        read_take,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata,
  // Counter pins
  input  wire        count_clk,
  input  wire        gate,
  output wire        cnt_out
);
  reg  [1:0]  rl_q;
  reg  [2:0]  mode_q;
  reg         bcd_q;
  reg  [15:0] cnt_q;
  reg  [15:0] init_q;
  reg  [7:0]  lsb_q;
  reg         wr_phase_q;
  reg         rd_phase_q;
  reg  [15:0] latch_q;
  reg         latched_q;
  reg         armed_q;
  reg         out_q;
  reg         gate_q;
  reg         trig_q;
  wire        clk_fall;
  wire        gate_rise;
  wire [15:0] cnt_dec;
  wire [15:0] view;
  wire        zero_next;
  wire        m_rate;
  wire        counting;
  ith_edge_sync u_clk (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .level_in(count_clk),
    .rise    (),
    .fall    (clk_fall)
  );
  ith_edge_sync u_gate (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .level_in(gate),
    .rise    (gate_rise),
    .fall    ()
  );
  // Four decades borrow digit by digit; zero wraps to the top of either radix.
  function [15:0] ith_dec;
    input [15:0] v;
    input        bcd;
    reg   [15:0] r;
    integer      i;
    reg          borrow;
    begin
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
        r = v - 16'h0001;
      end else begin
        for (i = 0; i < 4; i = i + 1) begin
          if (borrow) begin
            if (v[i*4 +: 4] == 4'h0) begin
              r[i*4 +: 4] = 4'h9;
            end else begin
              r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
              borrow = 1'b0;
            end
          end
        end
      end
      ith_dec = r;
    end
  endfunction
  assign cnt_dec   = ith_dec(cnt_q, bcd_q); // R19 R20
  assign zero_next = (cnt_dec == 16'h0000);
  assign m_rate    = mode_q[1];
  assign counting  = armed_q & (gate_q | mode_q == 3'h1 | mode_q == 3'h5);
  assign view      = latched_q ? latch_q : cnt_q;
  assign cnt_out   = out_q;
  always @* begin
    case (rl_q)
      `ITH_RL_MSB: rdata = view[15:8];
      `ITH_RL_BOTH: rdata = rd_phase_q ? view[15:8] : view[7:0];
      default: rdata = view[7:0];
    endcase
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rl_q       <= `ITH_RL_BOTH;
      mode_q     <= 3'h0;
      bcd_q      <= 1'b0;
      cnt_q      <= 16'h0000;
      init_q     <= 16'h0000;
      lsb_q      <= 8'h00;
      wr_phase_q <= 1'b0;
      rd_phase_q <= 1'b0;
      latch_q    <= 16'h0000;
      latched_q  <= 1'b0;
      armed_q    <= 1'b0;
      out_q      <= 1'b0;
      gate_q     <= 1'b0;
      trig_q     <= 1'b0;
    end else begin
      gate_q <= gate;
      if (cfg_we) begin // R10 R17
        trig_q     <= 1'b0;
        rl_q       <= cfg_word[5:4];
        mode_q     <= {cfg_word[3] & ~cfg_word[2], cfg_word[2:1]}; // R14
        bcd_q      <= cfg_word[0]; // R15
        wr_phase_q <= 1'b0;
        rd_phase_q <= 1'b0;
        latched_q  <= 1'b0;
        armed_q    <= 1'b0;
        out_q      <= (cfg_word[3:1] != 3'h0);
      end else if (latch_cmd && !latched_q) begin // R13
        latch_q   <= cnt_q;
        latched_q <= 1'b1;
      end else begin
        if (load_we) begin // R12
          if (rl_q == `ITH_RL_BOTH && !wr_phase_q) begin
            lsb_q      <= wdata;
            wr_phase_q <= 1'b1;
            if (mode_q == 3'h0) begin
              armed_q <= 1'b0;
            end
          end else begin
            wr_phase_q <= 1'b0;
            case (rl_q)
              `ITH_RL_LSB: init_q <= {8'h00, wdata};
              `ITH_RL_MSB: init_q <= {wdata, 8'h00};
              default: init_q <= {wdata, lsb_q};
            endcase
            if (mode_q == 3'h0 || mode_q == 3'h4 || !armed_q) begin
              case (rl_q)
                `ITH_RL_LSB: cnt_q <= {8'h00, wdata};
                `ITH_RL_MSB: cnt_q <= {wdata, 8'h00};
                default: cnt_q <= {wdata, lsb_q};
              endcase
              armed_q <= 1'b1;
              out_q   <= (mode_q != 3'h0);
            end
          end
        end
        if (read_take) begin
          if (rl_q == `ITH_RL_BOTH && !rd_phase_q) begin
            rd_phase_q <= 1'b1;
          end else begin
            rd_phase_q <= 1'b0;
            latched_q  <= 1'b0;
          end
        end
        // Decrement on the falling count clock edge; a control write, a latch that captures the count, or a count byte write to this counter in the same cycle skips it.
        if (clk_fall && counting && !load_we) begin // R2 R9 R18
          if ((mode_q == 3'h1 || mode_q == 3'h5) && trig_q) begin
            trig_q <= 1'b0;
            cnt_q  <= init_q;
            out_q  <= (mode_q == 3'h5);
          end else if (zero_next) begin
            cnt_q <= m_rate ? init_q : cnt_dec;
            out_q <= (mode_q == 3'h4 || mode_q == 3'h5) ? 1'b0 : (m_rate ? ~out_q | mode_q[0] == 1'b0 : 1'b1);
            if (mode_q == 3'h2) begin
              out_q <= 1'b0;
            end
          end else begin
            cnt_q <= cnt_dec;
            if (mode_q == 3'h2 || mode_q == 3'h4 || mode_q == 3'h5) begin
              out_q <= 1'b1;
            end
          end
        end
      end
      // A gate edge in the cycle that consumes or clears a trigger still keeps it.
      if (gate_rise) begin
        trig_q <= 1'b1;
      end
    end
  end
endmodule

// *** hdl/ith_top.v ***
// Bus front end and three counters of the interval timer.
//
// What this block does
// R1 - Deselected device ignores strobes, floats bus.
// R2 - Counters run whatever the select level; a count byte, control or capturing latch write to a counter drops a count edge in the same cycle.
// R3 - Write strobe alone accepts control or count byte.
// R4 - Read strobe alone drives addressed count byte.
// R5 - Port codes 00,01,10 pick counters 0-2.
// R6 - Port 11 write stores control; read floats.
// R7 - Control word is never readable.
// R8 - Data bus floats unless selected read.
// R9 - Three 16-bit down counters with own pins.
// R10 - Each counter keeps its own configuration.
// R11 - Control word top bits pick counter.
// R12 - Byte access: low, high, or low-then-high.
// R13 - Byte access 00 latches running count.
// R14 - Mode field picks modes 0 to 5.
// R15 - Bit 0 picks binary or decimal.
// R16 - Host writes control before count bytes.
// R17 - Stored control word governs its counter.
// R18 - Count clock works up to 2 MHz.
// R19 - Decimal counting uses four BCD digits.
// R20 - Zero load means full-range count.
// R21 - Host reads both bytes before writing.
// R22 - Illegal counter code 11 is discarded.
// R23 - One write strobe gives one update.
`timescale 1ns/1ns
`include "ith_defs.vh"
module ith_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Host bus
  input  wire        device_select_n,
  input  wire        read_n,
  input  wire        write_n,
  input  wire        port_select_lo,
  input  wire        port_select_hi,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output wire        data_oe,
  // Counter pins
  input  wire [2:0]  count_clk,
  input  wire [2:0]  gate,
  output wire [2:0]  cnt_out
);
  reg         wr_prev_q;
  reg         rd_prev_q;
  reg  [1:0]  rd_port_q;
  reg  [7:0]  mode_control_word_q;
  wire [1:0]  port;
  wire        sel;
  wire        wr_act;
  wire        rd_act;
  wire        wr_pulse;
  wire        rd_end;
  wire        cw_write;
  wire [1:0]  counter_pick;
  wire [1:0]  byte_access;
  wire [23:0] rd_bytes;
  assign port        = {port_select_hi, port_select_lo};
  assign sel         = ~device_select_n; // R1
  assign wr_act      = sel & ~write_n & read_n; // R3
  assign rd_act      = sel & ~read_n & write_n; // R4
  // Acting on the strobe edge alone keeps long strobes from repeating a load.
  assign wr_pulse    = wr_act & ~wr_prev_q; // R23
  assign rd_end      = ~rd_act & rd_prev_q;
  assign cw_write    = wr_pulse & (port == `ITH_PORT_CTRL); // R6
  assign counter_pick = data_in[`ITH_CW_SEL_HI:`ITH_CW_SEL_LO]; // R11
  assign byte_access = data_in[`ITH_CW_RL_HI:`ITH_CW_RL_LO];
  // Float unless a selected read addresses a counter; port 11 never drives.
  assign data_oe     = rd_act & (port != `ITH_PORT_CTRL); // R6 R7 R8
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_prev_q           <= 1'b0;
      rd_prev_q           <= 1'b0;
      rd_port_q           <= 2'h0;
      mode_control_word_q <= `ITH_CW_RESET;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
      // The port is kept from the read itself, since a host may move the address as the strobe ends.
      if (rd_act) begin
        rd_port_q <= port;
      end
      if (cw_write) begin
        mode_control_word_q <= data_in; // R6
      end
    end
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= 8'h00;
    end else if (rd_act) begin
      case (port)
        2'h0: data_out <= rd_bytes[7:0]; // R5
        2'h1: data_out <= rd_bytes[15:8];
        2'h2: data_out <= rd_bytes[23:16];
        default: data_out <= 8'h00;
      endcase
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      wire hit_cw;
      assign hit_cw = cw_write & (counter_pick == g) & (counter_pick != `ITH_SEL_ILLEGAL); // R22
      ith_counter u_cnt (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .cfg_we   (hit_cw & (byte_access != `ITH_RL_LATCH)),
        .cfg_word (data_in[5:0]),
        .latch_cmd(hit_cw & (byte_access == `ITH_RL_LATCH)), // R13
        .load_we  (wr_pulse & (port == g)), // R5
        .read_take(rd_end & (rd_port_q == g)),
        .wdata    (data_in),
        .rdata    (rd_bytes[g*8 +: 8]),
        .count_clk(count_clk[g]),
        .gate     (gate[g]),
        .cnt_out  (cnt_out[g])
      );
    end
  endgenerate
endmodule

// *** tb/ith_top_sva.sv ***
// Bus pin and counter 0 output assertions for the interval timer host port.
`timescale 1ns/1ns
module ith_top_sva (
  // Clock and reset
  input wire       ref_clk,
  input wire       resetn,
  // Host bus
  input wire       device_select_n,
  input wire       read_n,
  input wire       write_n,
  input wire       port_select_lo,
  input wire       port_select_hi,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  input wire       data_oe,
  // Counter pins
  input wire [2:0] count_clk,
  input wire [2:0] gate,
  input wire [2:0] cnt_out
);
  wire p11    = port_select_hi & port_select_lo;
  wire sel_rd = !device_select_n & !read_n & write_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_desel; device_select_n |-> !data_oe; endproperty
  a_desel: assert property (p_desel) else $error("driven while deselected");
  property p_ctrl_rd; p11 |-> !data_oe; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control port driven");
  property p_idle; read_n && write_n |-> !data_oe; endproperty
  a_idle: assert property (p_idle) else $error("driven while idle");
  property p_wr; !write_n |-> !data_oe; endproperty
  a_wr: assert property (p_wr) else $error("driven during write");
  property p_drive; sel_rd && !p11 |-> data_oe; endproperty
  a_drive: assert property (p_drive) else $error("read not driven");
  // Read data must not wander while the host is still sampling it.
  property p_hold; sel_rd && $past(sel_rd) ##1 sel_rd |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rd_end; $rose(read_n) |-> !data_oe; endproperty
  a_rd_end: assert property (p_rd_end) else $error("driven after read");
  property p_cfg;
    !device_select_n && read_n && $fell(write_n) && p11 && data_in[7:6] == 2'h0
      && data_in[5:4] != 2'h0 && data_in[3:1] == 3'h0 |-> ##[1:3] !cnt_out[0];
  endproperty
  a_cfg: assert property (p_cfg) else $error("mode 0 output not low");
endmodule
bind ith_top ith_top_sva i_ith_top_sva (.ref_clk(ref_clk), .resetn(resetn),
  .device_select_n(device_select_n), .read_n(read_n), .write_n(write_n),
  .port_select_lo(port_select_lo), .port_select_hi(port_select_hi), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .count_clk(count_clk), .gate(gate), .cnt_out(cnt_out));

// *** tb/ith_host_model.sv ***
// Host processor model driving the timer bus.
`timescale 1ns/1ns
module ith_host_model (
  // Clock
  input  wire       ref_clk,
  // Bus to device
  output reg        device_select_n,
  output reg        read_n,
  output reg        write_n,
  output reg  [1:0] port,
  output reg  [7:0] data_in,
  // Bus from device
  input  wire [7:0] data_out,
  input  wire       data_oe
);
  initial begin
    device_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    port = 2'h0;
    data_in = 8'h5a;
  end
  // Callers program a control word before its count bytes.
  task wr(input logic sel_n, input logic [1:0] p, input logic [7:0] d, input int width);
    begin
      @(negedge ref_clk);
      device_select_n = sel_n;
      port = p;
      data_in = d;
      write_n = 1'b0;
      repeat (width) @(negedge ref_clk);
      write_n = 1'b1;
      device_select_n = 1'b1;
      // Released data is inverted so a stale byte cannot pass for a fresh one.
      data_in = ~d;
    end
  endtask
  // Callers finish both bytes of a two-byte read before writing.
  task rd(input logic sel_n, input logic [1:0] p, output logic [7:0] d, output logic oe);
    begin
      @(negedge ref_clk);
      device_select_n = sel_n;
      port = p;
      read_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      d = data_out;
      oe = data_oe;
      read_n = 1'b1;
      device_select_n = 1'b1;
    end
  endtask
endmodule

// *** tb/test_interval_timer_host_port.sv ***
// Self-checking bench for the interval timer host port.
`timescale 1ns/1ns
module test_interval_timer_host_port;
  reg         ref_clk;
  reg         resetn;
  reg  [2:0]  count_clk;
  reg  [2:0]  gate;
  wire        device_select_n;
  wire        read_n;
  wire        write_n;
  wire [1:0]  port;
  wire [7:0]  data_in;
  wire [7:0]  data_out;
  wire        data_oe;
  wire [2:0]  cnt_out;
  int         bad_count;
  int         n_tests;
  logic [7:0] rv;
  logic       oe;
  int         m;
  always #5 ref_clk = ~ref_clk;
  ith_top i_ith_top (.ref_clk(ref_clk), .resetn(resetn), .device_select_n(device_select_n),
    .read_n(read_n), .write_n(write_n), .port_select_lo(port[0]), .port_select_hi(port[1]),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .count_clk(count_clk),
    .gate(gate), .cnt_out(cnt_out));
  ith_host_model i_ith_host_model (.ref_clk(ref_clk), .device_select_n(device_select_n),
    .read_n(read_n), .write_n(write_n), .port(port), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task rd_chk(input logic [1:0] p, input logic [7:0] exp);
    begin
      i_ith_host_model.rd(1'b0, p, rv, oe);
      chk("count byte", exp, rv);
      chk("drive", 8'h01, {7'h00, oe});
    end
  endtask
  task wr(input logic [1:0] p, input logic [7:0] d);
    begin
      i_ith_host_model.wr(1'b0, p, d, 1);
    end
  endtask
  // Count clock stays at 60 reference cycles a period, inside the 2 MHz limit.
  task pulse(input int idx, input int n);
    begin
      repeat (n) begin
        count_clk[idx] = 1'b1;
        repeat (30) @(negedge ref_clk);
        count_clk[idx] = 1'b0;
        repeat (30) @(negedge ref_clk);
      end
    end
  endtask
  task t_two_byte;
    begin
      wr(2'h3, 8'h30);
      i_ith_host_model.wr(1'b0, 2'h0, 8'h34, 5);
      wr(2'h0, 8'h12);
      rd_chk(2'h0, 8'h34);
      rd_chk(2'h0, 8'h12);
      $display("two byte test done");
    end
  endtask
  task t_msb_illegal;
    begin
      wr(2'h3, 8'h60);
      wr(2'h1, 8'hab);
      rd_chk(2'h1, 8'hab);
      wr(2'h3, 8'hd1);
      rd_chk(2'h0, 8'h34);
      rd_chk(2'h0, 8'h12);
      rd_chk(2'h1, 8'hab);
      $display("byte order test done");
    end
  endtask
  task t_refuse;
    begin
      i_ith_host_model.wr(1'b1, 2'h0, 8'h55, 1);
      i_ith_host_model.rd(1'b1, 2'h0, rv, oe);
      chk("deselected drive", 8'h00, {7'h00, oe});
      i_ith_host_model.rd(1'b0, 2'h3, rv, oe);
      chk("control drive", 8'h00, {7'h00, oe});
      rd_chk(2'h0, 8'h34);
      rd_chk(2'h0, 8'h12);
      $display("refusal test done");
    end
  endtask
  task t_modes;
    begin
      for (m = 0; m < 6; m = m + 1) begin
        wr(2'h3, {4'h9, m[2:0], 1'b0});
        wr(2'h2, 8'h07);
        chk("mode out", (m != 0) ? 8'h01 : 8'h00, {7'h00, cnt_out[2]});
        rd_chk(2'h2, 8'h07);
      end
      wr(2'h3, 8'h91);
      wr(2'h2, 8'h10);
      pulse(2, 1);
      rd_chk(2'h2, 8'h09);
      $display("mode and radix test done");
    end
  endtask
  task t_latch;
    begin
      wr(2'h3, 8'h70);
      wr(2'h1, 8'h00);
      wr(2'h1, 8'h01);
      pulse(1, 3);
      wr(2'h3, 8'h40);
      pulse(1, 2);
      chk("out 1 counting", 8'h00, {7'h00, cnt_out[1]});
      rd_chk(2'h1, 8'hfd);
      rd_chk(2'h1, 8'h00);
      $display("latch test done");
    end
  endtask
  task t_out;
    begin
      wr(2'h3, 8'h10);
      wr(2'h0, 8'h02);
      chk("out 0 loaded", 8'h00, {7'h00, cnt_out[0]});
      gate[0] = 1'b0;
      pulse(0, 1);
      rd_chk(2'h0, 8'h02);
      gate[0] = 1'b1;
      pulse(0, 1);
      chk("out 0 counting", 8'h00, {7'h00, cnt_out[0]});
      pulse(0, 1);
      chk("out 0 terminal", 8'h01, {7'h00, cnt_out[0]});
      wr(2'h0, 8'h00);
      chk("out 0 reloaded", 8'h00, {7'h00, cnt_out[0]});
      pulse(0, 1);
      rd_chk(2'h0, 8'hff);
      wr(2'h3, 8'h11);
      wr(2'h0, 8'h00);
      pulse(0, 1);
      rd_chk(2'h0, 8'h99);
      $display("output test done");
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count = bad_count + 1;
    results();
  end
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    count_clk = 3'h0;
    gate = 3'h7;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    t_two_byte();
    t_msb_illegal();
    t_refuse();
    t_modes();
    t_latch();
    t_out();
    results();
  end
endmodule
